// file: logic/motion_seq_map.svh
// Operation
// RL1: queue flush empties the addressed axis queue
// RL2: kill all flushes, stops every axis abruptly
// RL3: stop all flushes, ramps every axis down
// RL4: stop and clear also clears done flags
// RL5: stop at position uses given target, ramp
// RL6: single axis stop flushes and decelerates axis
// RL7: counted loops nest four deep per axis
// RL8: loop count 1 to 32000, repeated that often
// RL9: loop end closes innermost open loop
// RL10: while block repeats while flag set
// RL11: clear while drops flag, ending loop
// RL12: sync while repeats only while sync true
// RL13: home forward seeks switch, inits position
// RL14: home reverse seeks backwards, inits position
// RL15: home then kill stops pulses without ramp
// RL16: wait input low holds queue until low
// RL17: interrupt clear drops done and errors
// RL18: notified move completion sets done, signals host
// RL19: serial notify sends hex character on link
// RL20: sync wait holds until all release line
// RL21: wait all holds until every move finished
// RL22: timed wait holds queue given milliseconds
// RL23: motion starts only on go command
// RL24: queue entries run strictly in arrival order
`ifndef MOTION_SEQ_MAP_SVH
`define MOTION_SEQ_MAP_SVH

`define REG_CMD        8'h00
`define REG_STATUS     8'h04
`define REG_CTRL       8'h08

`define CMD_OP_LSB     24
`define CMD_AXIS_LSB   20
`define CMD_ARG_LSB    0

`define STAT_DONE_LSB  0
`define STAT_ERR_LSB   8
`define STAT_BUSY_LSB  16
`define STAT_WHILE_LSB 24

`define CTRL_RESET     32'h0000_0000

`define LOOP_DEPTH     4
`define LOOP_MAX       32000
`define LOOP_MIN       1

`define WAIT_UNIT_NS   1000000
`define CLK_PERIOD_NS  4

`endif

// file: logic/motion_seq_pkg.sv
package motion_seq_pkg;

	typedef enum logic [4:0] {
		nop_cmd                   = 5'b00000,
		go_cmd                    = 5'b00001,
		queue_flush_cmd           = 5'b00010,
		kill_all_cmd              = 5'b00011,
		kill_selected_cmd         = 5'b00100,
		stop_all_cmd              = 5'b00101,
		stop_and_clear_cmd        = 5'b00110,
		single_axis_stop_cmd      = 5'b00111,
		stop_at_position_cmd      = 5'b01000,
		loop_start_cmd            = 5'b01001,
		loop_end_cmd              = 5'b01010,
		while_block_cmd           = 5'b01011,
		while_terminator_cmd      = 5'b01100,
		clear_while_cmd           = 5'b01101,
		sync_while_cmd            = 5'b01110,
		sync_while_terminator_cmd = 5'b01111,
		home_forward_cmd          = 5'b10000,
		home_reverse_cmd          = 5'b10001,
		home_then_kill_cmd        = 5'b10010,
		home_reverse_then_kill_cmd = 5'b10011,
		wait_input_low_cmd        = 5'b10100,
		clear_axis_done_cmd       = 5'b10101,
		interrupt_clear_cmd       = 5'b10110,
		notify_done_cmd           = 5'b10111,
		serial_done_notify_cmd    = 5'b11000,
		sync_wait_cmd             = 5'b11001,
		wait_all_cmd              = 5'b11010,
		timed_wait_cmd            = 5'b11011
	} opcode_t;

	typedef enum logic [2:0] {
		EX_RUN   = 3'b000,
		EX_HOME  = 3'b001,
		EX_INPUT = 3'b010,
		EX_SYNC  = 3'b011,
		EX_ALL   = 3'b100,
		EX_TIME  = 3'b101
	} exec_t;

endpackage

// file: logic/motion_command_sequencer.sv
`timescale 1ns/10ps
`include "motion_seq_map.svh"

module motion_command_sequencer #(
	parameter int N         = 4,
	parameter int QDEPTH    = 16,
	parameter int NIN       = 8,
	parameter int MS_CYCLES = `WAIT_UNIT_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rstn,
	// wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output      logic [31:0]             wb_dat_o,
	output      logic                    wb_ack_o,
	// motion engine, same clock
	input  wire logic [N-1:0]            axis_busy,
	output      logic [N-1:0]            go_pulse,
	output      logic [N-1:0]            kill_pulse,
	output      logic [N-1:0]            stop_pulse,
	output      logic [N-1:0]            stop_at_pulse,
	output      logic [N-1:0][19:0]      stop_target,
	output      logic [19:0]             stop_ramp_dist,
	output      logic [N-1:0]            pos_init_pulse,
	output      logic [N-1:0]            home_seek,
	output      logic [N-1:0]            home_reverse,
	// pins
	input  wire logic [N-1:0]            home_sw,
	input  wire logic [NIN-1:0]          user_in,
	input  wire logic                    sync_i,
	output      logic                    sync_o,
	output      logic                    sync_oe,
	// serial done notification
	input  wire logic                    tx_ready,
	output      logic                    tx_valid,
	output      logic [7:0]              tx_data
);
	import motion_seq_pkg::*;

	localparam int AW  = $clog2(QDEPTH);
	localparam int PW  = AW + 1;
	localparam int AXW = (N > 1) ? $clog2(N) : 1;
	localparam int SLW = $clog2(NIN);
	localparam int MW  = $clog2(MS_CYCLES);

	function automatic logic [14:0] clamp_count(input logic [19:0] v);
		if (v < 20'(`LOOP_MIN))
			return 15'(`LOOP_MIN);
		else if (v > 20'(`LOOP_MAX))
			return 15'(`LOOP_MAX);
		else
			return v[14:0];
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] v);
		return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
	endfunction

	// pin synchronisers
	logic [N-1:0]    home_s1, home_s2;
	logic [NIN-1:0]  in_s1, in_s2;
	logic            sync_s1, sync_s2;

	always_ff @(posedge clk) begin
		home_s1 <= home_sw;
		home_s2 <= home_s1;
		in_s1   <= user_in;
		in_s2   <= in_s1;
		sync_s1 <= sync_i;
		sync_s2 <= sync_s1;
	end

	// bus decode
	wire             bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire             full_sel = (wb_sel_i == 4'hf);
	wire             cmd_wr   = bus_req & wb_we_i & full_sel & (wb_adr_i == `REG_CMD);
	wire             ctrl_wr  = bus_req & wb_we_i & full_sel & (wb_adr_i == `REG_CTRL);
	wire opcode_t    cmd_op   = opcode_t'(wb_dat_i[`CMD_OP_LSB +: 5]);
	wire [AXW-1:0]   cmd_axis = wb_dat_i[`CMD_AXIS_LSB +: AXW];
	wire [19:0]      cmd_arg  = wb_dat_i[`CMD_ARG_LSB +: 20];
	wire             axis_ok  = ({28'h000_0000, wb_dat_i[`CMD_AXIS_LSB +: 4]} < 32'(N));
	wire             immediate = (cmd_op == queue_flush_cmd) || (cmd_op == kill_all_cmd) ||
		(cmd_op == kill_selected_cmd) || (cmd_op == stop_all_cmd) ||
		(cmd_op == stop_and_clear_cmd) || (cmd_op == single_axis_stop_cmd) ||
		(cmd_op == stop_at_position_cmd) || (cmd_op == clear_while_cmd) ||
		(cmd_op == interrupt_clear_cmd);

	// per-axis state, then the shared millisecond time base
	logic [24:0]     qmem [N][QDEPTH];
	logic [PW-1:0]   wr_ptr [N];
	logic [PW-1:0]   rd_ptr [N];
	logic [PW-1:0]   base_ptr [N];
	exec_t           ex [N];
	logic [2:0]      depth [N];
	logic [14:0]     loop_cnt [N][`LOOP_DEPTH];
	logic [PW-1:0]   loop_addr [N][`LOOP_DEPTH];
	logic [N-1:0]    whl_flag, whl_open, swl_open;
	logic [PW-1:0]   whl_addr [N];
	logic [PW-1:0]   swl_addr [N];
	logic [SLW-1:0]  wait_sel [N];
	logic [19:0]     tmr [N];
	logic [N-1:0]    home_kill, notify_pend, serial_pend, armed, serial_arm;
	logic [N-1:0]    done, err, tx_pend, busy_q;
	logic [MW-1:0]   ms_cnt;
	logic            ms_tick;

	// one millisecond time base shared by all axes
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ms_cnt  <= '0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= (ms_cnt == MW'(MS_CYCLES - 1));
			ms_cnt  <= (ms_cnt == MW'(MS_CYCLES - 1)) ? '0 : ms_cnt + 1'b1;
		end
	end

	wire             all_idle = (axis_busy == '0) && (home_seek == '0);
	wire [N-1:0]     axis_done_now = armed & busy_q & ~axis_busy & serial_arm;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			go_pulse       <= '0;
			kill_pulse     <= '0;
			stop_pulse     <= '0;
			stop_at_pulse  <= '0;
			stop_target    <= '0;
			pos_init_pulse <= '0;
			home_seek      <= '0;
			home_reverse   <= '0;
			home_kill      <= '0;
			whl_flag       <= '0;
			whl_open       <= '0;
			swl_open       <= '0;
			notify_pend    <= '0;
			serial_pend    <= '0;
			armed          <= '0;
			serial_arm     <= '0;
			done           <= '0;
			err            <= '0;
			tx_pend        <= '0;
			busy_q         <= '0;
			for (int a = 0; a < N; a++) begin
				wr_ptr[a]   <= '0;
				rd_ptr[a]   <= '0;
				base_ptr[a] <= '0;
				ex[a]       <= EX_RUN;
				depth[a]    <= '0;
				whl_addr[a] <= '0;
				swl_addr[a] <= '0;
				wait_sel[a] <= '0;
				tmr[a]      <= '0;
			end
		end else begin
			go_pulse       <= '0;
			kill_pulse     <= '0;
			stop_pulse     <= '0;
			stop_at_pulse  <= '0;
			pos_init_pulse <= '0;
			busy_q         <= axis_busy;
			for (int a = 0; a < N; a++) begin
				// cleared ahead of everything else, so an error raised in this cycle still lands
				if (cmd_wr && cmd_op == interrupt_clear_cmd)
					err[a] <= 1'b0; // RL17
				// executor: one entry per cycle, strictly in order
				if (ex[a] == EX_RUN && rd_ptr[a] != wr_ptr[a]) begin // RL24
					rd_ptr[a] <= rd_ptr[a] + 1'b1;
					case (opcode_t'(qmem[a][rd_ptr[a][AW-1:0]][24:20]))
						go_cmd: begin
							go_pulse[a]   <= 1'b1; // RL23
							armed[a]      <= notify_pend[a];
							serial_arm[a] <= serial_pend[a];
							notify_pend[a] <= 1'b0;
							serial_pend[a] <= 1'b0;
						end
						loop_start_cmd: begin
							if (depth[a] == 3'(`LOOP_DEPTH)) begin
								err[a] <= 1'b1; // RL7
							end else begin
								loop_cnt[a][depth[a][1:0]]  <= clamp_count(qmem[a][rd_ptr[a][AW-1:0]][19:0]); // RL8
								loop_addr[a][depth[a][1:0]] <= rd_ptr[a] + 1'b1;
								depth[a] <= depth[a] + 1'b1; // RL7
							end
						end
						loop_end_cmd: begin
							if (depth[a] != '0) begin
								if (loop_cnt[a][2'(depth[a] - 1'b1)] > 15'h0001) begin
									loop_cnt[a][2'(depth[a] - 1'b1)] <= loop_cnt[a][2'(depth[a] - 1'b1)] - 1'b1; // RL8
									rd_ptr[a] <= loop_addr[a][2'(depth[a] - 1'b1)]; // RL9
								end else begin
									depth[a] <= depth[a] - 1'b1; // RL9
								end
							end
						end
						while_block_cmd: begin
							whl_flag[a] <= 1'b1;
							whl_open[a] <= 1'b1;
							whl_addr[a] <= rd_ptr[a] + 1'b1;
						end
						while_terminator_cmd: begin
							if (whl_flag[a])
								rd_ptr[a] <= whl_addr[a]; // RL10
							else
								whl_open[a] <= 1'b0;
						end
						sync_while_cmd: begin
							swl_open[a] <= 1'b1;
							swl_addr[a] <= rd_ptr[a] + 1'b1;
						end
						sync_while_terminator_cmd: begin
							if (sync_s2)
								rd_ptr[a] <= swl_addr[a]; // RL12
							else
								swl_open[a] <= 1'b0;
						end
						home_forward_cmd, home_reverse_cmd, home_then_kill_cmd, home_reverse_then_kill_cmd: begin
							home_seek[a]    <= 1'b1; // RL13
							home_reverse[a] <= qmem[a][rd_ptr[a][AW-1:0]][20]; // RL14
							home_kill[a]    <= qmem[a][rd_ptr[a][AW-1:0]][21]; // RL15
							ex[a]           <= EX_HOME;
						end
						wait_input_low_cmd: begin
							wait_sel[a] <= qmem[a][rd_ptr[a][AW-1:0]][SLW-1:0];
							ex[a]       <= EX_INPUT; // RL16
						end
						clear_axis_done_cmd: done[a] <= 1'b0;
						notify_done_cmd: begin
							notify_pend[a] <= 1'b1;
							serial_pend[a] <= 1'b0;
						end
						serial_done_notify_cmd: begin
							notify_pend[a] <= 1'b1;
							serial_pend[a] <= 1'b1; // RL19
						end
						sync_wait_cmd: ex[a] <= EX_SYNC; // RL20
						wait_all_cmd: ex[a] <= EX_ALL; // RL21
						timed_wait_cmd: begin
							tmr[a] <= qmem[a][rd_ptr[a][AW-1:0]][19:0];
							if (qmem[a][rd_ptr[a][AW-1:0]][19:0] != '0)
								ex[a] <= EX_TIME; // RL22
						end
						default: ;
					endcase
				end else begin
					case (ex[a])
						EX_HOME: if (home_s2[a]) begin
							home_seek[a]      <= 1'b0;
							pos_init_pulse[a] <= 1'b1; // RL13
							kill_pulse[a]     <= home_kill[a]; // RL15
							stop_pulse[a]     <= ~home_kill[a];
							ex[a]             <= EX_RUN;
						end
						EX_INPUT: if (!in_s2[wait_sel[a]]) ex[a] <= EX_RUN; // RL16
						EX_SYNC: if (sync_s2) ex[a] <= EX_RUN; // RL20
						EX_ALL: if (all_idle) ex[a] <= EX_RUN; // RL21
						// the tick phase runs free, so one extra tick keeps a wait from ending short
						EX_TIME: if (ms_tick) begin
							tmr[a] <= tmr[a] - 1'b1; // RL22
							if (tmr[a] == 20'h0_0000)
								ex[a] <= EX_RUN;
						end
						default: ;
					endcase
				end

				// entries are only released once no loop can return to them
				if (depth[a] == '0 && !whl_open[a] && !swl_open[a])
					base_ptr[a] <= rd_ptr[a];

				// host commands into this axis
				if (cmd_wr && axis_ok && !immediate && cmd_axis == AXW'(a)) begin
					if (wr_ptr[a] - base_ptr[a] == PW'(QDEPTH)) begin
						err[a] <= 1'b1;
					end else begin
						qmem[a][wr_ptr[a][AW-1:0]] <= {cmd_op, cmd_arg};
						wr_ptr[a] <= wr_ptr[a] + 1'b1;
					end
				end
				if (cmd_wr && immediate) begin
					if ((cmd_op == queue_flush_cmd && cmd_axis == AXW'(a)) || // RL1
						cmd_op == kill_all_cmd || cmd_op == stop_all_cmd || cmd_op == stop_and_clear_cmd ||
						(cmd_op == kill_selected_cmd && cmd_arg[a]) ||
						(cmd_op == single_axis_stop_cmd && cmd_axis == AXW'(a))) begin
						rd_ptr[a]   <= wr_ptr[a];
						base_ptr[a] <= wr_ptr[a];
						depth[a]    <= '0;
						whl_flag[a] <= 1'b0;
						whl_open[a] <= 1'b0;
						swl_open[a] <= 1'b0;
						ex[a]       <= EX_RUN;
						if (cmd_op != queue_flush_cmd)
							home_seek[a] <= 1'b0;
					end
					if (cmd_op == kill_all_cmd || (cmd_op == kill_selected_cmd && cmd_arg[a]))
						kill_pulse[a] <= 1'b1; // RL2
					if (cmd_op == stop_all_cmd || cmd_op == stop_and_clear_cmd) // RL3
						stop_pulse[a] <= 1'b1; // RL4
					if (cmd_op == single_axis_stop_cmd && cmd_axis == AXW'(a))
						stop_pulse[a] <= 1'b1; // RL6
					if (cmd_op == stop_at_position_cmd && cmd_axis == AXW'(a)) begin
						stop_at_pulse[a] <= 1'b1; // RL5
						stop_target[a]   <= cmd_arg;
					end
					if (cmd_op == clear_while_cmd && cmd_axis == AXW'(a))
						whl_flag[a] <= 1'b0; // RL11
					if (cmd_op == stop_and_clear_cmd)
						done[a] <= 1'b0; // RL4
					if (cmd_op == interrupt_clear_cmd)
						done[a] <= 1'b0; // RL17
				end
				if (cmd_wr && !axis_ok && cmd_op != kill_all_cmd && cmd_op != stop_all_cmd &&
					cmd_op != stop_and_clear_cmd && cmd_op != interrupt_clear_cmd &&
					cmd_op != kill_selected_cmd && a == 0)
					err[a] <= 1'b1;

				// completion of a notified move; set comes last so it beats any clear
				if (armed[a] && busy_q[a] && !axis_busy[a]) begin
					armed[a] <= 1'b0;
					done[a]  <= 1'b1; // RL18
					if (serial_arm[a])
						tx_pend[a] <= 1'b1; // RL19
				end
			end
			if (!tx_valid && tx_pend != '0)
				tx_pend <= (tx_pend & (tx_pend - 1'b1)) | axis_done_now; // RL19
		end
	end

	// serial notification: one hex character, the axis number, per completion
	logic [3:0]      tx_axis;

	always_comb begin
		tx_axis = '0;
		for (int a = N - 1; a >= 0; a--)
			if (tx_pend[a])
				tx_axis = 4'(a);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
		end else if (tx_valid) begin
			if (tx_ready)
				tx_valid <= 1'b0;
		end else if (tx_pend != '0) begin
			tx_valid <= 1'b1;
			tx_data  <= hex_char(tx_axis); // RL19
		end
	end

	// shared sync line: held low except while an axis waits on it or runs a sync-while block;
	// letting go inside the block is what lets its own terminator ever see the line high
	logic [N-1:0]    sync_wait;

	always_comb begin
		for (int a = 0; a < N; a++)
			sync_wait[a] = (ex[a] == EX_SYNC) || swl_open[a]; // RL12
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync_o  <= 1'b0;
			sync_oe <= 1'b1;
		end else begin
			sync_o  <= 1'b0;
			sync_oe <= (sync_wait == '0); // RL20
		end
	end

	// register read view
	logic [31:0]     status_word;

	always_comb begin
		status_word = '0;
		for (int a = 0; a < N; a++) begin
			status_word[`STAT_DONE_LSB + a]  = done[a];
			status_word[`STAT_ERR_LSB + a]   = err[a];
			status_word[`STAT_BUSY_LSB + a]  = (ex[a] != EX_RUN) || (rd_ptr[a] != wr_ptr[a]);
			status_word[`STAT_WHILE_LSB + a] = whl_flag[a];
		end
	end

	wire [31:0]      read_word = (wb_adr_i == `REG_STATUS) ? status_word :
		(wb_adr_i == `REG_CTRL) ? {12'h000, stop_ramp_dist} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wb_ack_o       <= 1'b0;
			wb_dat_o       <= 32'h0000_0000;
			stop_ramp_dist <= 20'(`CTRL_RESET);
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? read_word : 32'h0000_0000;
			if (ctrl_wr)
				stop_ramp_dist <= wb_dat_i[19:0]; // RL5
		end
	end

endmodule

// file: sim/seq_checker_assertions.sv
`timescale 1ns/10ps
module seq_checker
	import motion_seq_pkg::*;
#(
	parameter int N = 4
) (
	// clock and reset
	input wire logic                clk,
	input wire logic                rstn,
	// bus
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [7:0]          wb_adr_i,
	input wire logic [3:0]          wb_sel_i,
	input wire logic [31:0]         wb_dat_i,
	input wire logic [31:0]         wb_dat_o,
	input wire logic                wb_ack_o,
	// motion and serial
	input wire logic [N-1:0]        kill_pulse,
	input wire logic [N-1:0]        stop_pulse,
	input wire logic [N-1:0]        stop_at_pulse,
	input wire logic [N-1:0][19:0]  stop_target,
	input wire logic                sync_o,
	input wire logic                tx_ready,
	input wire logic                tx_valid,
	input wire logic [7:0]          tx_data
);
	wire logic [3:0] axis_f = wb_dat_i[23:20];
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence cmd_wr(logic [4:0] op);
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i == 4'hf && wb_dat_i[28:24] == op;
	endsequence
	sequence axis_cmd(logic [4:0] op);
		cmd_wr(op) ##0 axis_f < N;
	endsequence
	ack_answer_a:
	assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
	ack_pulse_a:
	assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	dat_idle_a:
	assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data without ack");
	sync_low_a:
	assert property (sync_o == 1'b0) else $error("sync output drives high");
	kill_all_a:
	assert property (cmd_wr(kill_all_cmd) |=> kill_pulse == '1) else $error("kill all missed an axis");
	stop_all_a:
	assert property (cmd_wr(stop_all_cmd) |=> stop_pulse == '1) else $error("stop all missed an axis");
	axis_stop_a:
	assert property (axis_cmd(single_axis_stop_cmd) |=> stop_pulse[$past(axis_f)]) else $error("axis stop missing");
	stop_at_a:
	assert property (axis_cmd(stop_at_position_cmd) |=> stop_at_pulse[$past(axis_f)]
		&& stop_target[$past(axis_f)] == $past(wb_dat_i[19:0])) else $error("stop at position wrong");
	tx_hold_a:
	assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("serial char dropped");
endmodule

bind motion_command_sequencer seq_checker #(.N(N)) i_chk (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .kill_pulse, .stop_pulse, .stop_at_pulse, .stop_target, .sync_o,
	.tx_ready, .tx_valid, .tx_data);

// file: sim/motion_engine_model.sv
`timescale 1ns/10ps
module motion_engine_model #(
	parameter int N   = 4,
	parameter int RUN = 12
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rstn,
	// commands from the sequencer
	input  wire logic [N-1:0]  go_pulse,
	input  wire logic [N-1:0]  kill_pulse,
	input  wire logic [N-1:0]  stop_pulse,
	input  wire logic [N-1:0]  stop_at_pulse,
	output      logic [N-1:0]  axis_busy,
	// serial character sink
	input  wire logic          stall,
	input  wire logic          tx_valid,
	output      logic          tx_ready
);
	int left [N];
	// a stop still ramps for a few cycles, a kill ends at once
	always_ff @(posedge clk) begin
		for (int a = 0; a < N; a++) begin
			if (!rstn || kill_pulse[a])
				left[a] <= 0;
			else if ((stop_pulse[a] || stop_at_pulse[a]) && left[a] > 3)
				left[a] <= 3;
			else if (go_pulse[a])
				left[a] <= RUN;
			else if (left[a] > 0)
				left[a] <= left[a] - 1;
		end
	end
	always_comb begin
		for (int a = 0; a < N; a++) axis_busy[a] = left[a] != 0;
	end
	assign tx_ready = tx_valid & ~stall;
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
module tb;
	import motion_seq_pkg::*;
	localparam int N  = 4;
	localparam int MS = 20;
	logic                clk = 1'b0;
	logic                rstn = 1'b0;
	logic                wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]          wb_adr_i = 8'h00;
	logic [3:0]          wb_sel_i = 4'h0;
	logic [31:0]         wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	logic                wb_ack_o, sync_i, sync_o, sync_oe, tx_ready, tx_valid;
	logic [7:0]          tx_data, user_in = 8'hff;
	logic [N-1:0]        axis_busy, go_pulse, kill_pulse, stop_pulse, stop_at_pulse;
	logic [N-1:0]        pos_init_pulse, home_seek, home_reverse, home_sw = '0;
	logic [N-1:0][19:0]  stop_target;
	logic [19:0]         stop_ramp_dist;
	logic                other_rel = 1'b1, stall = 1'b0;
	int                  err_count = 0, tests_run = 0, n, g0;
	int                  gcnt [N] = '{default: 0};

	always #2 clk = ~clk;
	// open-drain sync wire: low while anyone pulls it
	assign sync_i = other_rel & ~sync_oe;

	motion_command_sequencer #(.N(N), .MS_CYCLES(MS)) i_dut (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .axis_busy, .go_pulse, .kill_pulse, .stop_pulse, .stop_at_pulse,
		.stop_target, .stop_ramp_dist, .pos_init_pulse, .home_seek, .home_reverse, .home_sw, .user_in, .sync_i,
		.sync_o, .sync_oe, .tx_ready, .tx_valid, .tx_data);
	motion_engine_model #(.N(N)) i_eng (.clk, .rstn, .go_pulse, .kill_pulse, .stop_pulse, .stop_at_pulse,
		.axis_busy, .stall, .tx_valid, .tx_ready);

	always @(posedge clk) begin
		for (int a = 0; a < N; a++) begin
			if (go_pulse[a] === 1'b1) gcnt[a]++;
		end
	end

	task automatic conclude();
		$display("checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic fail_wait();
		err_count++;
		$display("BAD %0t: wait ran out", $time);
		conclude();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int i;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 20) fail_wait();
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic cmd(input opcode_t op, input logic [3:0] a, input logic [19:0] g);
		bus(8'h00, 1'b1, {3'b000, op, a, g});
	endtask
	task automatic wait_status(input int b, input logic e);
		int i;
		for (i = 0; i < 40; i++) begin
			bus(8'h04, 1'b0, 32'h0000_0000);
			if (rd[b] === e) break;
		end
		if (i == 40) fail_wait();
	endtask
	// c stays -1 when no go shows within the window
	task automatic wait_go(input int a, input int lim, output int c);
		c = -1;
		for (int i = 0; i < lim && c < 0; i++) begin
			@(posedge clk);
			if (go_pulse[a] === 1'b1) c = i;
		end
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		bus(8'h08, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		bus(8'h08, 1'b1, 32'h0001_2345);
		bus(8'h08, 1'b0, 32'h0000_0000);
		check(rd, 32'h0001_2345);
		check(stop_ramp_dist, 20'h1_2345);
		bus(8'h3c, 1'b0, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		$display("test registers done");
		cmd(stop_at_position_cmd, 4'h2, 20'h0_0abc);
		@(posedge clk);
		check(stop_target[2], 20'h0_0abc);
		cmd(kill_selected_cmd, 4'h0, 20'h0_0005);
		check(kill_pulse, 4'h5);
		cmd(single_axis_stop_cmd, 4'h1, 20'h0_0000);
		cmd(kill_all_cmd, 4'h0, 20'h0_0000);
		cmd(stop_all_cmd, 4'h0, 20'h0_0000);
		$display("test stops done");
		stall <= 1'b1;
		cmd(serial_done_notify_cmd, 4'h1, 20'h0_0000);
		cmd(go_cmd, 4'h1, 20'h0_0000);
		wait_status(1, 1'b1);
		repeat (8) @(posedge clk);
		check(tx_valid, 1'b1);
		check(tx_data, 8'h31);
		stall <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			cmd(notify_done_cmd, 4'h0, 20'h0_0000);
			cmd(go_cmd, 4'h0, 20'h0_0000);
			wait_status(0, 1'b1);
			cmd(k ? stop_and_clear_cmd : interrupt_clear_cmd, 4'h0, 20'h0_0000);
			bus(8'h04, 1'b0, 32'h0000_0000);
			check(rd[7:0], 8'h00);
		end
		$display("test done flags done");
		cmd(timed_wait_cmd, 4'h2, 20'h0_0005);
		cmd(go_cmd, 4'h2, 20'h0_0000);
		cmd(queue_flush_cmd, 4'h2, 20'h0_0000);
		wait_go(2, 200, n);
		check(n, -1);
		cmd(timed_wait_cmd, 4'h3, 20'h0_0003);
		cmd(go_cmd, 4'h3, 20'h0_0000);
		wait_go(3, 200, n);
		check(n >= 3 * MS - 4 && n <= 4 * MS, 1'b1);
		cmd(wait_input_low_cmd, 4'h0, 20'h0_0002);
		cmd(go_cmd, 4'h0, 20'h0_0000);
		wait_go(0, 30, n);
		check(n, -1);
		user_in <= 8'hfb;
		wait_go(0, 20, n);
		check(n >= 0, 1'b1);
		other_rel <= 1'b0;
		cmd(sync_wait_cmd, 4'h1, 20'h0_0000);
		cmd(go_cmd, 4'h1, 20'h0_0000);
		wait_go(1, 30, n);
		check(n, -1);
		check(sync_oe, 1'b0);
		other_rel <= 1'b1;
		wait_go(1, 20, n);
		check(n >= 0, 1'b1);
		cmd(go_cmd, 4'h0, 20'h0_0000);
		cmd(wait_all_cmd, 4'h2, 20'h0_0000);
		cmd(go_cmd, 4'h2, 20'h0_0000);
		wait_go(2, 100, n);
		check(n >= 0, 1'b1);
		check(axis_busy[0], 1'b0);
		$display("test waits done");
		for (int k = 0; k < 2; k++) begin
			g0 = gcnt[0];
			cmd(loop_start_cmd, 4'h0, k ? 20'h0_0003 : 20'h0_0000);
			cmd(go_cmd, 4'h0, 20'h0_0000);
			cmd(loop_end_cmd, 4'h0, 20'h0_0000);
			repeat (30) @(posedge clk);
			check(gcnt[0] - g0, k ? 3 : 1);
		end
		for (int k = 0; k < 5; k++) begin
			cmd(loop_start_cmd, 4'h3, 20'h0_0001);
			bus(8'h04, 1'b0, 32'h0000_0000);
			check(rd[11], k == 4);
		end
		cmd(queue_flush_cmd, 4'h3, 20'h0_0000);
		cmd(interrupt_clear_cmd, 4'h0, 20'h0_0000);
		bus(8'h04, 1'b0, 32'h0000_0000);
		check(rd[11], 1'b0);
		$display("test loops done");
		g0 = gcnt[0];
		cmd(while_block_cmd, 4'h0, 20'h0_0000);
		cmd(go_cmd, 4'h0, 20'h0_0000);
		cmd(while_terminator_cmd, 4'h0, 20'h0_0000);
		bus(8'h04, 1'b0, 32'h0000_0000);
		check(rd[24], 1'b1);
		cmd(clear_while_cmd, 4'h0, 20'h0_0000);
		check(gcnt[0] - g0 > 2, 1'b1);
		g0 = gcnt[0];
		repeat (12) @(posedge clk);
		check(gcnt[0] - g0 < 3, 1'b1);
		g0 = gcnt[3];
		cmd(sync_while_cmd, 4'h3, 20'h0_0000);
		cmd(go_cmd, 4'h3, 20'h0_0000);
		cmd(sync_while_terminator_cmd, 4'h3, 20'h0_0000);
		repeat (4) @(posedge clk);
		other_rel <= 1'b0;
		check(gcnt[3] - g0 > 1, 1'b1);
		repeat (6) @(posedge clk);
		g0 = gcnt[3];
		repeat (12) @(posedge clk);
		check(gcnt[3] - g0, 0);
		other_rel <= 1'b1;
		$display("test while loops done");
		for (int k = 0; k < 4; k++) begin
			cmd(opcode_t'(5'h10 + 5'(k)), 4'(k), 20'h0_0000);
			repeat (4) @(posedge clk);
			check(home_seek[k], 1'b1);
			check(home_reverse[k], k[0]);
			home_sw[k] <= 1'b1;
			for (n = 0; n < 10 && pos_init_pulse[k] !== 1'b1; n++) @(posedge clk);
			check(n < 10, 1'b1);
			check(kill_pulse[k], k[1]);
			check(stop_pulse[k], !k[1]);
			home_sw[k] <= 1'b0;
		end
		$display("test homing done");
		conclude();
	end
endmodule
